// [hw/fbpim_pkg.sv]
// Package: constants and types of the fieldbus master process image map
package fbpim_pkg;
    // Image length codes (bytes): 12, 20, 24, 32, 40, 48
    localparam logic [2:0] LEN_SEL_12 = 3'h0;
    localparam logic [2:0] LEN_SEL_20 = 3'h1;
    localparam logic [2:0] LEN_SEL_24 = 3'h2;
    localparam logic [2:0] LEN_SEL_32 = 3'h3;
    localparam logic [2:0] LEN_SEL_40 = 3'h4;
    localparam logic [2:0] LEN_SEL_48 = 3'h5;
    // Mailbox size codes (bytes): 0, 6, 10, 12, 18
    localparam logic [2:0] MBX_SEL_0  = 3'h0;
    localparam logic [2:0] MBX_SEL_6  = 3'h1;
    localparam logic [2:0] MBX_SEL_10 = 3'h2;
    localparam logic [2:0] MBX_SEL_12 = 3'h3;
    localparam logic [2:0] MBX_SEL_18 = 3'h4;
    // Image geometry
    localparam int IMG_WORDS_MAX = 24;
    localparam int IMG_WORDS_MIN = 6;
    localparam int PD_BYTES_MAX  = 46;
    localparam logic [4:0] CSB_WORD_OFS = 5'h00;
    localparam logic [4:0] MBX_WORD_OFS = 5'h01;
    localparam logic [7:0] CSB_HIGH_RST = 8'h00;
    localparam logic [15:0] WORD_RST    = 16'h0000;
    // Setup after reset: 12 words (24 bytes) with no mailbox
    localparam logic [4:0] LEN_WORDS_RST = 5'h0c;
    localparam logic [4:0] MBX_WORDS_RST = 5'h00;
    // Mailbox modes
    typedef enum logic {FBPIM_MODE_OVERLAID, FBPIM_MODE_SUPPRESSIBLE} fbpim_mode_t;
    // Word classification
    typedef enum logic [1:0] {FBPIM_W_CSB, FBPIM_W_MBX, FBPIM_W_PD, FBPIM_W_NONE}
        fbpim_wkind_t;

    // Image length in words for a length code; 0 marks an illegal code
    function automatic logic [4:0] fbpim_len_words(input logic [2:0] sel);
        case (sel)
            LEN_SEL_12: fbpim_len_words = 5'h06;
            LEN_SEL_20: fbpim_len_words = 5'h0a;
            LEN_SEL_24: fbpim_len_words = 5'h0c;
            LEN_SEL_32: fbpim_len_words = 5'h10;
            LEN_SEL_40: fbpim_len_words = 5'h14;
            LEN_SEL_48: fbpim_len_words = 5'h18;
            default:    fbpim_len_words = 5'h00;
        endcase
    endfunction

    // Mailbox length in words for a size code; 5'h1f marks an illegal code
    function automatic logic [4:0] fbpim_mbx_words(input logic [2:0] sel);
        case (sel)
            MBX_SEL_0:  fbpim_mbx_words = 5'h00;
            MBX_SEL_6:  fbpim_mbx_words = 5'h03;
            MBX_SEL_10: fbpim_mbx_words = 5'h05;
            MBX_SEL_12: fbpim_mbx_words = 5'h06;
            MBX_SEL_18: fbpim_mbx_words = 5'h09;
            default:    fbpim_mbx_words = 5'h1f;
        endcase
    endfunction
endpackage

// [hw/fbpim_word_class.sv]
// Word classifier: decides what a word offset of the image carries
`timescale 1ns/100ps
module fbpim_word_class
    import fbpim_pkg::*;
(
    input  wire logic [4:0]   word_idx,
    input  wire logic [4:0]   len_words,
    input  wire logic [4:0]   mbx_words,
    input  wire logic         mbx_visible,
    output fbpim_wkind_t      kind,
    output logic [5:0]        byte_ofs
);
    // Mailbox words follow word zero; process data fills the rest
    always_comb begin
        kind     = FBPIM_W_NONE;
        byte_ofs = 6'h00;
        if (word_idx >= len_words) begin
            kind = FBPIM_W_NONE;
        end else if (word_idx == CSB_WORD_OFS) begin
            kind = FBPIM_W_CSB;
        end else if (mbx_visible && (word_idx < (MBX_WORD_OFS + mbx_words))) begin
            kind     = FBPIM_W_MBX;
            byte_ofs = 6'({word_idx - MBX_WORD_OFS, 1'b0});
        end else begin
            kind     = FBPIM_W_PD;
            byte_ofs = 6'({word_idx - MBX_WORD_OFS, 1'b0});
        end
    end
endmodule

// [hw/fbpim_map.sv]
// Main file: process image map for the bus master I/O module
`timescale 1ns/100ps
// Notes on behaviour
// - Image length 12,20,24,32,40 or 48 bytes
// - Mailbox size 0,6,10,12 or 18 bytes
// - Process data spans zero to 46 bytes
// - Images span 6 to 24 aligned words
// - Word zero low byte is control/status byte
// - Overlaid mailbox sits right after word zero
// - Suppressible mode: hideable mailbox then data
// - Remaining words carry cyclic process data
module fbpim_map
    import fbpim_pkg::*;
#(
    parameter int WORDS_MAX = IMG_WORDS_MAX
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic [2:0]   cfg_len_sel,
    input  wire logic [2:0]   cfg_mbx_sel,
    input  wire logic         cfg_mode,
    input  wire logic         cfg_load,
    input  wire logic         mbx_show,
    // Host side: word access to both images
    input  wire logic         host_rd,
    input  wire logic         host_wr,
    input  wire logic [4:0]   host_addr,
    input  wire logic [15:0]  host_wdata,
    output logic [15:0]       host_rdata,
    output logic              host_rvalid,
    output logic              host_err,
    // Device side: control/status byte, mailbox and process data out and in
    output logic [7:0]        ctrl_byte,
    output logic [8*PD_BYTES_MAX-1:0] out_bytes,
    input  wire logic [7:0]   status_byte,
    input  wire logic [8*PD_BYTES_MAX-1:0] in_bytes,
    output logic [4:0]        len_words_out,
    output logic [4:0]        mbx_words_out,
    output logic [5:0]        pd_bytes_out,
    output logic              cfg_err
);
    // Elaboration check: flattening and decoding assume a 24 word image
    if (WORDS_MAX != IMG_WORDS_MAX) begin : g_bad_words
        $error("WORDS_MAX must equal IMG_WORDS_MAX of 24 words");
    end

    // ************************************************************
    // Static configuration
    // ************************************************************
    logic [4:0]   len_words_reg;
    logic [4:0]   mbx_words_reg;
    fbpim_mode_t  mode_reg;
    logic [4:0]   len_words_next;
    logic [4:0]   mbx_words_next;
    logic         cfg_ok;

    assign len_words_next = fbpim_len_words(cfg_len_sel);
    assign mbx_words_next = fbpim_mbx_words(cfg_mbx_sel);
    // Mailbox must leave room for word zero; illegal codes are refused
    assign cfg_ok = (len_words_next != 5'h00) && (mbx_words_next != 5'h1f)
                    && ((mbx_words_next + 5'h01) <= len_words_next);

    // Configuration is only taken on an explicit load, so it stays static
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            len_words_reg <= LEN_WORDS_RST;
            mbx_words_reg <= MBX_WORDS_RST;
            mode_reg      <= FBPIM_MODE_OVERLAID;
            cfg_err       <= 1'b0;
        end else if (clk_en && cfg_load) begin
            cfg_err <= !cfg_ok;
            if (cfg_ok) begin
                len_words_reg <= len_words_next;
                mbx_words_reg <= mbx_words_next;
                mode_reg      <= fbpim_mode_t'(cfg_mode);
            end
        end
    end

    // Derived geometry published for the device logic
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            len_words_out <= 5'h00;
            mbx_words_out <= 5'h00;
            pd_bytes_out  <= 6'h00;
        end else if (clk_en) begin
            len_words_out <= len_words_reg;
            mbx_words_out <= mbx_words_reg;
            pd_bytes_out  <= 6'({len_words_reg - 5'h01, 1'b0});
        end
    end

    // ************************************************************
    // Mailbox visibility
    // ************************************************************
    logic mbx_show_s1_reg;
    logic mbx_show_s2_reg;
    logic mbx_visible;

    // Show request may come from another domain, so it is synchronised
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mbx_show_s1_reg <= 1'b0;
            mbx_show_s2_reg <= 1'b0;
        end else if (clk_en) begin
            mbx_show_s1_reg <= mbx_show;
            mbx_show_s2_reg <= mbx_show_s1_reg;
        end
    end

    // Overlaid mailbox is always visible; suppressible one only on request
    assign mbx_visible = (mode_reg == FBPIM_MODE_OVERLAID) ? 1'b1
                         : mbx_show_s2_reg;

    // ************************************************************
    // Image storage
    // ************************************************************
    // Output image: word 0 control byte, then 23 data words
    logic [15:0] out_img_reg [WORDS_MAX];
    fbpim_wkind_t kind;
    logic [5:0]   byte_ofs;

    fbpim_word_class u_class (
        .word_idx    (host_addr),
        .len_words   (len_words_reg),
        .mbx_words   (mbx_words_reg),
        .mbx_visible (mbx_visible),
        .kind        (kind),
        .byte_ofs    (byte_ofs)
    );

    // Host writes of the output image; high byte of word zero stays zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < WORDS_MAX; i++) begin
                out_img_reg[i] <= WORD_RST;
            end
        end else if (clk_en && host_wr && (kind != FBPIM_W_NONE)) begin
            if (kind == FBPIM_W_CSB) begin
                out_img_reg[0] <= {CSB_HIGH_RST, host_wdata[7:0]};
            end else begin
                out_img_reg[host_addr] <= host_wdata;
            end
        end
    end

    // Flatten the output image towards the device logic
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_byte <= 8'h00;
            out_bytes <= '0;
        end else if (clk_en) begin
            ctrl_byte <= out_img_reg[0][7:0];
            for (int w = 1; w < WORDS_MAX; w++) begin
                out_bytes[16*(w-1) +: 16] <= out_img_reg[w];
            end
        end
    end

    // ************************************************************
    // Host reads of the input image
    // ************************************************************
    logic [15:0] rd_word;
    always_comb begin
        rd_word = WORD_RST;
        case (kind)
            FBPIM_W_CSB:  rd_word = {CSB_HIGH_RST, status_byte};
            FBPIM_W_MBX:  rd_word = in_bytes[8*byte_ofs +: 16];
            FBPIM_W_PD:   rd_word = in_bytes[8*byte_ofs +: 16];
            default:      rd_word = WORD_RST;
        endcase
    end

    // Out of range accesses answer with zero data and an error flag
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            host_rdata  <= WORD_RST;
            host_rvalid <= 1'b0;
            host_err    <= 1'b0;
        end else if (clk_en) begin
            host_rvalid <= host_rd;
            host_err    <= (host_rd || host_wr) && (kind == FBPIM_W_NONE);
            host_rdata  <= host_rd ? rd_word : WORD_RST;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_LEN_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (len_words_reg >= 5'h06) && (len_words_reg <= 5'h18))
        else $error("image length out of range");
    AST_LEN_EVEN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        len_words_reg inside {5'h06, 5'h0a, 5'h0c, 5'h10, 5'h14, 5'h18})
        else $error("image length not a legal size");
    AST_MBX_SIZE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        mbx_words_reg inside {5'h00, 5'h03, 5'h05, 5'h06, 5'h09})
        else $error("mailbox size not legal");
    AST_PD_MAX: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en |=> (pd_bytes_out <= 6'd46))
        else $error("process data beyond 46 bytes");
    AST_CSB_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clk_en && host_rd && kind == FBPIM_W_CSB) |=> (host_rdata[15:8] == 8'h00))
        else $error("status word high byte not zero");
    AST_CSB_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clk_en && host_rd && kind == FBPIM_W_CSB)
        |=> (host_rdata[7:0] == $past(status_byte)))
        else $error("status byte not returned at word zero");
    AST_OVL_VIS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mode_reg == FBPIM_MODE_OVERLAID) |-> mbx_visible)
        else $error("overlaid mailbox hidden");
    AST_SUP_HIDE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mode_reg == FBPIM_MODE_SUPPRESSIBLE && !mbx_show_s2_reg && host_addr == 5'h01
         && len_words_reg > 5'h01) |-> (kind == FBPIM_W_PD))
        else $error("hidden mailbox still mapped");
    AST_CFG_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !cfg_load |=> $stable(len_words_reg))
        else $error("length changed without load");
    AST_RVALID: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clk_en && host_rd) |=> host_rvalid)
        else $error("read not answered");

    COV_MBX_READ: cover property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && host_rd && kind == FBPIM_W_MBX);
    COV_PD_READ: cover property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && host_rd && kind == FBPIM_W_PD);
    COV_OOR: cover property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && host_wr && kind == FBPIM_W_NONE);
endmodule

// [verification/fbpim_host_model.sv]
// Host controller model: loads the static image setup and makes word accesses
`timescale 1ns/100ps
module fbpim_host_model (
    input  wire logic         clk_sys,
    output logic [2:0]        cfg_len_sel,
    output logic [2:0]        cfg_mbx_sel,
    output logic              cfg_mode,
    output logic              cfg_load,
    output logic              host_rd,
    output logic              host_wr,
    output logic [4:0]        host_addr,
    output logic [15:0]       host_wdata,
    input  wire logic [15:0]  host_rdata,
    input  wire logic         host_rvalid,
    input  wire logic         host_err
);
    // Idle bus at time zero
    initial begin
        {cfg_len_sel, cfg_mbx_sel, cfg_mode, cfg_load} = '0;
        {host_rd, host_wr, host_addr, host_wdata} = '0;
    end
    // Setup is loaded once and left alone before traffic resumes
    task automatic cfg(input logic [2:0] l, input logic [2:0] m, input logic md);
        @(posedge clk_sys);
        cfg_len_sel <= l;
        cfg_mbx_sel <= m;
        cfg_mode    <= md;
        cfg_load    <= 1'b1;
        @(posedge clk_sys);
        cfg_load <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // Read pulse, then a bounded wait for the answer
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic e);
        int n;
        @(posedge clk_sys);
        host_rd   <= 1'b1;
        host_addr <= a;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        #1;
        n = 0;
        while (host_rvalid !== 1'b1 && host_err !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        d = host_rdata;
        e = (n < 4) ? host_err : 1'bx;
    endtask
    // Write pulse; the refusal flag is gathered over the next cycles
    task automatic wr(input logic [4:0] a, input logic [15:0] d, output logic e);
        @(posedge clk_sys);
        host_wr    <= 1'b1;
        host_addr  <= a;
        host_wdata <= d;
        @(posedge clk_sys);
        host_wr <= 1'b0;
        e = 1'b0;
        repeat (3) begin
            #1;
            e = e | host_err;
            @(posedge clk_sys);
        end
    endtask
endmodule

// [verification/testbench.sv]
// Testbench of the process image map, with the host model on the word bus
`timescale 1ns/100ps
module testbench;
    import fbpim_pkg::*;
    logic clk_sys, rst_b, clk_en, mbx_show, cfg_mode, cfg_load, host_rd, host_wr;
    logic host_rvalid, host_err, cfg_err, e;
    logic [2:0]   cfg_len_sel, cfg_mbx_sel;
    logic [4:0]   host_addr, len_words_out, mbx_words_out;
    logic [5:0]   pd_bytes_out;
    logic [7:0]   ctrl_byte, status_byte;
    logic [15:0]  host_wdata, host_rdata, d;
    logic [367:0] out_bytes, in_bytes;
    int miscompares = 0;
    int samples_checked = 0;
    // ****************************************
    // Clock, reset and device side inputs
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        mbx_show = 1'b0;
        status_byte = 8'h00;
        for (int k = 0; k < 46; k++) in_bytes[8*k+:8] = 8'(k + 16);
    end
    fbpim_map dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
        .cfg_len_sel(cfg_len_sel), .cfg_mbx_sel(cfg_mbx_sel), .cfg_mode(cfg_mode),
        .cfg_load(cfg_load), .mbx_show(mbx_show), .host_rd(host_rd), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .host_err(host_err), .ctrl_byte(ctrl_byte),
        .out_bytes(out_bytes), .status_byte(status_byte), .in_bytes(in_bytes),
        .len_words_out(len_words_out), .mbx_words_out(mbx_words_out),
        .pd_bytes_out(pd_bytes_out), .cfg_err(cfg_err));
    fbpim_host_model host (.clk_sys(clk_sys), .cfg_len_sel(cfg_len_sel),
        .cfg_mbx_sel(cfg_mbx_sel), .cfg_mode(cfg_mode), .cfg_load(cfg_load),
        .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .host_err(host_err));
    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Expected input word w (w >= 1) from the byte pattern on in_bytes
    function automatic logic [15:0] in_word(input int w);
        return {8'(2*w - 1 + 16), 8'(2*w - 2 + 16)};
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    // Every length code: geometry, last word readable, word past the end refused
    task automatic t_lengths;
        int lw[6] = '{6, 10, 12, 16, 20, 24};
        chk("reset len", 32'(12), 32'(len_words_out));
        chk("reset pd", 32'(22), 32'(pd_bytes_out));
        for (int i = 0; i < 6; i++) begin
            host.cfg(3'(i), MBX_SEL_0, 1'b0);
            chk("len words", 32'(lw[i]), 32'(len_words_out));
            chk("pd bytes", 32'(2*lw[i] - 2), 32'(pd_bytes_out));
            host.rd(5'(lw[i] - 1), d, e);
            chk("last word", {16'(0), in_word(lw[i] - 1)}, {16'(0), d});
            host.rd(5'(lw[i]), d, e);
            chk("past end err", 32'(1), 32'(e));
        end
        host.cfg(3'h6, MBX_SEL_0, 1'b0);
        chk("bad len err", 32'(1), 32'(cfg_err));
        chk("bad len kept", 32'(24), 32'(len_words_out));
    endtask
    // Every mailbox code, then a mailbox that leaves no room
    task automatic t_mailbox;
        int mw[5] = '{0, 3, 5, 6, 9};
        for (int i = 0; i < 5; i++) begin
            host.cfg(LEN_SEL_48, 3'(i), 1'b0);
            chk("mbx words", 32'(mw[i]), 32'(mbx_words_out));
            chk("cfg ok", 32'(0), 32'(cfg_err));
        end
        host.cfg(LEN_SEL_12, MBX_SEL_12, 1'b0);
        chk("mbx too big", 32'(1), 32'(cfg_err));
        chk("mbx kept", 32'(9), 32'(mbx_words_out));
    endtask
    // Word zero carries only the low control/status byte
    task automatic t_word0;
        status_byte <= 8'ha5;
        host.rd(5'h00, d, e);
        chk("status word", 32'h0000_00a5, {16'(0), d});
        host.wr(5'h00, 16'h3cc3, e);
        chk("control byte", 32'h0000_00c3, {24'(0), ctrl_byte});
    endtask
    // Mailbox and data placement in both modes, writes into the output image
    task automatic t_layout;
        host.cfg(LEN_SEL_24, MBX_SEL_6, 1'b0);
        host.rd(5'h01, d, e);
        chk("mode1 mbx", {16'(0), in_word(1)}, {16'(0), d});
        host.rd(5'h04, d, e);
        chk("mode1 data", {16'(0), in_word(4)}, {16'(0), d});
        host.wr(5'h04, 16'h1234_, e);
        chk("out word4", 32'h0000_1234, {16'(0), out_bytes[48+:16]});
        host.wr(5'h0c, 16'hdead, e);
        chk("wr past end", 32'(1), 32'(e));
        host.cfg(LEN_SEL_24, MBX_SEL_6, 1'b1);
        for (int s = 0; s < 2; s++) begin
            mbx_show <= s[0];
            repeat (4) @(posedge clk_sys);
            host.rd(5'h01, d, e);
            chk("mode2 word1", {16'(0), in_word(1)}, {16'(0), d});
            host.rd(5'h0b, d, e);
            chk("mode2 last", {16'(0), in_word(11)}, {16'(0), d});
        end
    endtask
    // Frozen clock enable drops accesses; a mid-run reset restores the defaults
    task automatic t_freeze;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        host.wr(5'h05, 16'hbeef, e);
        chk("frozen wr err", 32'(0), 32'(e));
        host.cfg(LEN_SEL_48, MBX_SEL_0, 1'b0);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("frozen wr", 32'(0), {16'(0), out_bytes[64+:16]});
        chk("frozen cfg", 32'(12), 32'(len_words_out));
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("len in reset", 32'(0), 32'(len_words_out));
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("len after reset", 32'(12), 32'(len_words_out));
        chk("ctrl after reset", 32'(0), {24'(0), ctrl_byte});
        chk("word4 after reset", 32'(0), {16'(0), out_bytes[48+:16]});
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_lengths();
        t_mailbox();
        t_word0();
        t_layout();
        t_freeze();
        finish_test();
    end
    // Whole run needs under two hundred cycles; far beyond that means a hang
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end
endmodule
